// ### src/hub_cfg_pkg.sv
// Package for the hub configuration source selector.
// Assumes a single 200 MHz core clock domain.
package hub_cfg_pkg;
  // Core clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  // Least width of the external reset pulse, in ns
  localparam int unsigned RST_MIN_NS       = 100;
  // Cycles the reset must stay low, rounded up
  localparam int unsigned RST_MIN_CYCLES   = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Seven-bit slave address answered in download mode
  localparam logic [6:0]  SLAVE_ADDR       = 7'h2d;
  // Number of pins in the board test chain
  localparam int unsigned CHAIN_PINS       = 8;
  // Reset value of the latched selection
  localparam logic [1:0]  SEL_RESET        = 2'h0;

  // Configuration method chosen at reset release
  typedef enum logic [1:0] {
    METHOD_SMBUS,
    METHOD_DEFAULTS,
    METHOD_EEPROM
  } cfg_method_t;

  // Decode of the two select pins
  function automatic cfg_method_t decode_method(input logic hi, input logic lo);
    if (!hi) begin
      return METHOD_SMBUS;
    end else if (!lo) begin
      return METHOD_DEFAULTS;
    end
    return METHOD_EEPROM;
  endfunction
endpackage

// ### src/test_chain_if.sv
// Interface carrying the board test chain between selector and chain module.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface test_chain_if #(parameter int unsigned N = 8);
  logic [N-1:0] pins;
  logic         enable;
  logic         result;
  modport ctrl  (output pins, output enable, input result);
  modport chain (input pins, input enable, output result);
endinterface

// ### src/xnor_chain.sv
// Exclusive-NOR chain over the signal pins for board testing.
// Assumes the pin vector is synchronous to the core clock.
`timescale 1ns/1ps
module xnor_chain
  import hub_cfg_pkg::*;
#(
  parameter int unsigned N = CHAIN_PINS
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  test_chain_if.chain tc
);
  typedef struct packed {
    logic result;
  } chain_state_t;

  chain_state_t s_q;
  chain_state_t s_d;
  logic         acc;

  // Fold every pin through an XNOR stage, registered for a clean output
  always_comb begin
    acc = 1'b1;
    for (int i = 0; i < int'(N); i++) begin
      acc = ~(acc ^ tc.pins[i]);
    end
    s_d        = s_q;
    s_d.result = tc.enable ? acc : 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign tc.result = s_q.result;
endmodule // xnor_chain

// ### src/hub_config_source_select.sv
// Configuration source selector: latches the select pins at reset release.
// Assumes all pins are synchronous to core_clk_i; the pad ring does analog.
`timescale 1ns/1ps

// Behaviour
// - Upper select low at sampling picks SMBus slave download whatever the lower pin is.
// - In SMBus mode only the seven-bit address 0101101 is answered.
// - Upper high and lower low picks built-in defaults set by straps.
// - Both high picks EEPROM load and the lower pin is then only the serial clock.
// - Clock select low uses the crystal, high takes an external 24 MHz clock on the first pin.
// - Local power detect high means local supply, low means all power from upstream.
// - Both select pins are sampled on the rising edge ending reset.
module hub_config_source_select
  import hub_cfg_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  ext_rst_n_i,
  input  wire logic                  config_method_sel_hi_i,
  input  wire logic                  config_method_sel_lo_i,
  input  wire logic                  ext_clock_source_sel_i,
  input  wire logic                  local_power_detect_i,
  input  wire logic [1:0]            test_mode_i,
  input  wire logic [CHAIN_PINS-1:0] chain_pins_i,
  input  wire logic                  addr_valid_i,
  input  wire logic [6:0]            addr_i,
  output logic                       method_valid_o,
  output logic [1:0]                 method_o,
  output logic                       smbus_mode_o,
  output logic                       defaults_mode_o,
  output logic                       eeprom_mode_o,
  output logic                       addr_match_o,
  output logic                       osc_bypass_o,
  output logic                       osc_drive_en_o,
  output logic                       self_powered_o,
  output logic                       reset_valid_o,
  output logic                       chain_out_o
);
  typedef struct packed {
    logic        rst_n_prev;
    logic        valid;
    cfg_method_t method;
    logic        match;
    logic        bypass;
    logic        local_power_detect;
    logic [7:0]  low_cnt;
    logic        rst_ok;
  } sel_state_t;

  sel_state_t s_q;
  sel_state_t s_d;
  logic       rise;

  test_chain_if #(.N(CHAIN_PINS)) tc ();

  // Test chain is on only when a test input is raised
  assign tc.pins   = chain_pins_i;
  assign tc.enable = |test_mode_i;

  xnor_chain #(.N(CHAIN_PINS)) u_chain (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .tc         (tc.chain)
  );

  // Rising edge of the external reset
  assign rise = ext_rst_n_i & ~s_q.rst_n_prev;

  // Next-state logic
  always_comb begin
    s_d            = s_q;
    s_d.rst_n_prev = ext_rst_n_i;
    if (!ext_rst_n_i) begin
      s_d.valid = 1'b0;
      if (s_q.low_cnt != 8'hff) begin
        s_d.low_cnt = s_q.low_cnt + 8'h01;
      end
    end
    if (rise) begin
      s_d.method  = decode_method(config_method_sel_hi_i, config_method_sel_lo_i);
      s_d.valid   = 1'b1;
      s_d.rst_ok  = 32'(s_q.low_cnt) >= RST_MIN_CYCLES;
      s_d.low_cnt = '0;
    end
    // Address compare only while serving as SMBus slave
    s_d.match    = addr_valid_i && s_q.valid && (s_q.method == METHOD_SMBUS)
                   && (addr_i == SLAVE_ADDR);
    s_d.bypass   = ext_clock_source_sel_i;
    s_d.local_power_detect = local_power_detect_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q            <= '0;
      s_q.rst_n_prev <= 1'b1;
      s_q.method     <= cfg_method_t'(SEL_RESET);
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // Outputs from state
  assign method_valid_o  = s_q.valid;
  assign method_o        = s_q.method;
  assign smbus_mode_o    = s_q.valid && s_q.method == METHOD_SMBUS;
  assign defaults_mode_o = s_q.valid && s_q.method == METHOD_DEFAULTS;
  assign eeprom_mode_o   = s_q.valid && s_q.method == METHOD_EEPROM;
  assign addr_match_o    = s_q.match;
  assign osc_bypass_o    = s_q.bypass;
  assign osc_drive_en_o  = ~s_q.bypass;
  assign self_powered_o  = s_q.local_power_detect;
  assign reset_valid_o   = s_q.rst_ok;
  assign chain_out_o     = tc.result;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_release;
    clk_en_i && !s_q.rst_n_prev && ext_rst_n_i;
  endsequence

  a_sel_smbus: assert property (s_release ##0 !config_method_sel_hi_i |=> smbus_mode_o)
    else $error("SMBus mode not chosen");
  a_sel_defaults: assert property (s_release ##0 config_method_sel_hi_i
      && !config_method_sel_lo_i |=> defaults_mode_o)
    else $error("Defaults mode not chosen");
  a_sel_eeprom: assert property (s_release ##0 config_method_sel_hi_i
      && config_method_sel_lo_i |=> eeprom_mode_o)
    else $error("EEPROM mode not chosen");
  a_addr_only: assert property (clk_en_i && !(addr_valid_i && addr_i == SLAVE_ADDR
      && smbus_mode_o) |=> !addr_match_o)
    else $error("Wrong address matched");
  a_clk_source: assert property (clk_en_i |=> osc_bypass_o == $past(ext_clock_source_sel_i)
      && osc_drive_en_o != osc_bypass_o)
    else $error("Clock source wrong");
  a_power_detect: assert property (clk_en_i |=> self_powered_o == $past(local_power_detect_i))
    else $error("Power detect wrong");
  a_method_hold: assert property (method_valid_o && ext_rst_n_i && clk_en_i
      |=> $stable(method_o))
    else $error("Method changed without reset");
  a_chain_idle: assert property (clk_en_i && test_mode_i == 2'h0 |=> !chain_out_o)
    else $error("Chain active outside test");
  a_short_reset: assert property (s_release ##0 32'(s_q.low_cnt) < RST_MIN_CYCLES
      |=> !reset_valid_o)
    else $error("Short reset accepted");
endmodule // hub_config_source_select

// ### bench/cfg_host_model.sv
// Board and host model: external reset, select straps, received addresses.
// Assumes the bench clock; drives change by non-blocking assignment on its rising edge.
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic       core_clk_i,
  output logic            ext_rst_n_o,
  output logic            sel_hi_o,
  output logic            sel_lo_o,
  output logic            addr_valid_o,
  output logic [6:0]      addr_o
);
  // Idle board: reset released, straps pulled high
  initial begin
    ext_rst_n_o = 1'b1;
    sel_hi_o = 1'b1;
    sel_lo_o = 1'b1;
    addr_valid_o = 1'b0;
    addr_o = 7'h00;
  end
  // Low pulse of len cycles, straps set while low
  task automatic reset_pulse(input int len, input logic hi, input logic lo);
    @(posedge core_clk_i);
    ext_rst_n_o <= 1'b0;
    sel_hi_o <= hi;
    sel_lo_o <= lo;
    repeat (len) @(posedge core_clk_i);
    ext_rst_n_o <= 1'b1;
  endtask
  // One address with clock pin and strap activity, then a scrambled bus
  task automatic send_addr(input logic [6:0] a);
    @(posedge core_clk_i);
    addr_valid_o <= 1'b1;
    addr_o <= a;
    sel_lo_o <= ~sel_lo_o;
    sel_hi_o <= ~sel_hi_o;
    @(posedge core_clk_i);
    addr_valid_o <= 1'b0;
    addr_o <= ~a;
  endtask
endmodule // cfg_host_model

// ### bench/hub_config_source_select_tb_top.sv
// Top bench: reference model of the selector checked against the design each cycle.
// Assumes hub_cfg_pkg and the host model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module hub_config_source_select_tb_top;
  import hub_cfg_pkg::*;
  logic core_clk_i, reset_i, ext_sel, pwr_in, rst_n, s_hi, s_lo, a_vld, clk_en;
  logic [6:0] addr;
  logic [1:0] test_mode, method;
  logic [CHAIN_PINS-1:0] chain_pins;
  logic valid, smb, dfl, eep, match, byp, drv, pwr, rv, chain;
  int n_mismatch = 0, compares = 0;
  int m_val, m_meth, m_rv, m_match, m_byp, m_pwr, m_chain, lowcnt, prev, x;
  cfg_host_model host (.core_clk_i(core_clk_i), .ext_rst_n_o(rst_n), .sel_hi_o(s_hi),
    .sel_lo_o(s_lo), .addr_valid_o(a_vld), .addr_o(addr));
  hub_config_source_select DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .ext_rst_n_i(rst_n), .config_method_sel_hi_i(s_hi), .config_method_sel_lo_i(s_lo),
    .ext_clock_source_sel_i(ext_sel), .local_power_detect_i(pwr_in), .test_mode_i(test_mode),
    .chain_pins_i(chain_pins), .addr_valid_i(a_vld), .addr_i(addr), .method_valid_o(valid),
    .method_o(method), .smbus_mode_o(smb), .defaults_mode_o(dfl), .eeprom_mode_o(eep),
    .addr_match_o(match), .osc_bypass_o(byp), .osc_drive_en_o(drv), .self_powered_o(pwr),
    .reset_valid_o(rv), .chain_out_o(chain));
  // Reference model of the registered outputs
  always @(posedge core_clk_i) if (reset_i || clk_en) begin
    m_match = !reset_i && a_vld && addr == 7'h2d && m_val && m_meth == 0;
    m_byp = reset_i ? 0 : ext_sel;
    m_pwr = reset_i ? 0 : pwr_in;
    x = 1;
    for (int i = 0; i < CHAIN_PINS; i++) x = !(x ^ chain_pins[i]);
    m_chain = (!reset_i && test_mode != 0) ? x : 0;
    if (reset_i) begin
      m_val = 0;
      m_meth = 0;
      m_rv = 0;
      lowcnt = 0;
    end else if (!rst_n) begin
      m_val = 0;
      lowcnt = (lowcnt < 255) ? lowcnt + 1 : 255;
    end else if (!prev) begin
      m_val = 1;
      m_meth = !s_hi ? 0 : (!s_lo ? 1 : 2);
      m_rv = lowcnt >= 100 / 5;
    end else lowcnt = 0;
    prev = reset_i ? 1 : rst_n;
  end
  // Compare every output once a cycle, method and rst_ok only while valid, away from the edge
  always @(negedge core_clk_i) begin
    `CHK("valid", 1'(m_val), valid)
    if (m_val) `CHK("method", 2'(m_meth), method)
    `CHK("smbus", 1'(m_val && m_meth == 0), smb)
    `CHK("defaults", 1'(m_val && m_meth == 1), dfl)
    `CHK("eeprom", 1'(m_val && m_meth == 2), eep)
    `CHK("match", 1'(m_match), match)
    `CHK("bypass", 1'(m_byp), byp)
    `CHK("drive", 1'(!m_byp), drv)
    `CHK("power", 1'(m_pwr), pwr)
    `CHK("chain", 1'(m_chain), chain)
    if (m_val) `CHK("rst_ok", 1'(m_rv), rv)
  end
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // Random pin traffic with addresses, half of them the slave address
  task automatic traffic(input int n);
    repeat (n) begin
      host.send_addr(($urandom % 2) ? 7'h2d : 7'($urandom));
      ext_sel <= 1'($urandom);
      pwr_in <= 1'($urandom);
      test_mode <= 2'($urandom);
      chain_pins <= CHAIN_PINS'($urandom);
      clk_en <= 1'($urandom);
    end
    clk_en <= 1'b1;
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // All strap combinations, pulses at and below the minimum, then a mid-run reset
  initial begin
    reset_i = 1'b1;
    ext_sel = 1'b0;
    pwr_in = 1'b0;
    clk_en = 1'b1;
    test_mode = 2'h0;
    chain_pins = '0;
    void'($urandom(12));
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      host.reset_pulse((i < 4) ? 20 : 19, i[0], i[1]);
      traffic(12);
    end
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    traffic(4);
    host.reset_pulse(265, 1'b0, 1'b1);
    traffic(8);
    wrap_up();
  end
endmodule // hub_config_source_select_tb_top
